/* File: ucn_pkg.sv */
package ucn_pkg;

    // apb register map, byte addresses
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;

    // direction indices
    localparam int unsigned DIR_TX = 0;
    localparam int unsigned DIR_RX = 1;
    localparam int unsigned NUM_DIR = 2;

    // control register fields
    localparam int unsigned CTRL_TX_RST_BIT = 0;
    localparam int unsigned CTRL_RX_RST_BIT = 1;
    localparam int unsigned CTRL_TX_DIV_LSB = 4;
    localparam int unsigned CTRL_TX_RATIO_BIT = 7;
    localparam int unsigned CTRL_RX_DIV_LSB = 8;
    localparam int unsigned CTRL_RX_RATIO_BIT = 11;
    localparam int unsigned DIV_W = 3;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0ff3;
    localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;

    // status register fields
    localparam int unsigned STAT_TX_ACT_BIT = 0;
    localparam int unsigned STAT_RX_ACT_BIT = 1;
    localparam int unsigned STAT_TX_RST_BIT = 2;
    localparam int unsigned STAT_RX_RST_BIT = 3;

    // zero values for divider counter, active sync and data words
    localparam logic [DIV_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // apb request as one bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ucn_apb_req_t;

    // per-direction clocking state
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic pri;
        logic sec;
        logic [1:0] sync;
    } ucn_dir_t;

    // whole state of the helper
    typedef struct packed {
        ucn_dir_t [NUM_DIR-1:0] dir;
        logic [31:0] ctrl;
        logic [31:0] rdata;
    } ucn_state_t;

endpackage

/* File: ucn_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
// dependent reset sequencer fed by helper active
module ucn_seq_model
(
    input wire logic sys_clk,
    input wire logic active,
    input wire logic helper_reset,
    output logic done
);
    // finishes only once clocks reported active
    // clocking reset input mirrors the helper's own reset
    always_ff @(posedge sys_clk)
    begin
        done <= active & ~helper_reset;
    end
endmodule
`default_nettype wire

/* File: ucn_user_clock_helper.sv */
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - one source clock derives every user clock
// - tx primary clock: buffered, divided from source
// - tx secondary clock: extra division when ratio set
// - rx primary clock: buffered, divided from source
// - rx secondary clock: extra division when ratio set
// - active high only while resources out of reset
// - core active input fed from helper active
// - source clock presented as an output
// - tx reset sequence waits for tx active
// - rx reset sequence waits for rx active
module ucn_user_clock_helper
    import ucn_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tx_helper_reset,
    input wire logic rx_helper_reset,
    input wire ucn_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_source_clock,
    output logic tx_primary_user_clock,
    output logic tx_secondary_user_clock,
    output logic tx_active,
    output logic rx_source_clock,
    output logic rx_primary_user_clock,
    output logic rx_secondary_user_clock,
    output logic rx_active
);

    ucn_state_t state_r;
    ucn_state_t state_nxt;
    logic [NUM_DIR-1:0] rst_dir;
    logic [NUM_DIR-1:0] sec_rise;
    logic [DIV_W-1:0] div_sel [NUM_DIR];
    logic [NUM_DIR-1:0] ratio_sel;

    // address decode shared by error answer and its assertion
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFS) || (a == STAT_OFS);
    endfunction

    // read data for an address
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input ucn_state_t s,
                                              input logic [NUM_DIR-1:0] r);
        logic [31:0] w;
        w = DATA_ZERO;
        if (a == CTRL_OFS)
        begin
            w = s.ctrl;
        end
        else if (a == STAT_OFS)
        begin
            w[STAT_TX_ACT_BIT] = s.dir[DIR_TX].sync[1];
            w[STAT_RX_ACT_BIT] = s.dir[DIR_RX].sync[1];
            w[STAT_TX_RST_BIT] = r[DIR_TX];
            w[STAT_RX_RST_BIT] = r[DIR_RX];
        end
        return w;
    endfunction

    // effective helper reset and config per direction
    always_comb
    begin
        rst_dir[DIR_TX] = tx_helper_reset | state_r.ctrl[CTRL_TX_RST_BIT];
        rst_dir[DIR_RX] = rx_helper_reset | state_r.ctrl[CTRL_RX_RST_BIT];
        div_sel[DIR_TX] = state_r.ctrl[CTRL_TX_DIV_LSB +: DIV_W];
        div_sel[DIR_RX] = state_r.ctrl[CTRL_RX_DIV_LSB +: DIV_W];
        ratio_sel[DIR_TX] = state_r.ctrl[CTRL_TX_RATIO_BIT];
        ratio_sel[DIR_RX] = state_r.ctrl[CTRL_RX_RATIO_BIT];
    end

    // next state: dividers, active sync, apb registers
    always_comb
    begin
        state_nxt = state_r;
        sec_rise = '0;
        for (int d = 0; d < NUM_DIR; d++)
        begin
            if (rst_dir[d])
            begin
                // buffers cleared, active dropped at once
                state_nxt.dir[d].cnt = CNT_ZERO;
                state_nxt.dir[d].pri = 1'b0;
                state_nxt.dir[d].sec = 1'b0;
                state_nxt.dir[d].sync = SYNC_ZERO;
            end
            else
            begin
                // primary: half period of div+1 source cycles
                if (state_r.dir[d].cnt == div_sel[d])
                begin
                    state_nxt.dir[d].cnt = CNT_ZERO;
                    state_nxt.dir[d].pri = ~state_r.dir[d].pri;
                    // secondary follows primary or halves it
                    if (!ratio_sel[d])
                    begin
                        state_nxt.dir[d].sec = ~state_r.dir[d].pri;
                    end
                    else if (!state_r.dir[d].pri)
                    begin
                        state_nxt.dir[d].sec = ~state_r.dir[d].sec;
                    end
                end
                else
                begin
                    state_nxt.dir[d].cnt = state_r.dir[d].cnt + 3'h1;
                end
                sec_rise[d] = state_nxt.dir[d].sec & ~state_r.dir[d].sec;
                // release walks two stages on secondary rising edges
                if (sec_rise[d])
                begin
                    state_nxt.dir[d].sync = {state_r.dir[d].sync[0], 1'b1};
                end
            end
        end
        // apb write in access phase
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == CTRL_OFS)
        begin
            state_nxt.ctrl = apb_req.pwdata & CTRL_MASK;
        end
        // read data captured in setup phase
        if (apb_req.psel && !apb_req.penable)
        begin
            state_nxt.rdata = read_word(apb_req.paddr, state_r, rst_dir);
        end
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_r <= '{dir: '0, ctrl: CTRL_RST_VAL, rdata: DATA_ZERO};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // apb answer: one wait-free access phase
    assign pready = apb_req.psel & apb_req.penable;
    assign pslverr = apb_req.psel & apb_req.penable & ~addr_mapped(apb_req.paddr);
    assign prdata = state_r.rdata;

    // source clock presented out, user clocks from flops
    assign tx_source_clock = sys_clk;
    assign rx_source_clock = sys_clk;
    assign tx_primary_user_clock = state_r.dir[DIR_TX].pri;
    assign tx_secondary_user_clock = state_r.dir[DIR_TX].sec;
    assign rx_primary_user_clock = state_r.dir[DIR_RX].pri;
    assign rx_secondary_user_clock = state_r.dir[DIR_RX].sec;
    // active feeds the reset controller's active input
    assign tx_active = state_r.dir[DIR_TX].sync[1];
    assign rx_active = state_r.dir[DIR_RX].sync[1];

    // checks run on the source clock, quiet under block reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // per-direction clocking checks
    for (genvar g = 0; g < NUM_DIR; g++)
    begin : g_chk
        sequence reset_release_s;
            rst_dir[g] ##1 !rst_dir[g];
        endsequence

        sequence two_low_s;
            !state_r.dir[g].sync[1] ##1 !state_r.dir[g].sync[1];
        endsequence

        property release_slow_p;
            reset_release_s |-> two_low_s;
        endproperty

        clock_cleared_a: assert property (rst_dir[g] |=> !state_r.dir[g].pri && !state_r.dir[g].sec)
            else $error("user clock not cleared under helper reset");

        active_drop_a: assert property (rst_dir[g] |=> !state_r.dir[g].sync[1])
            else $error("active stayed high after helper reset");

        active_rise_a: assert property (release_slow_p)
            else $error("active rose too soon after reset release");

        active_cause_a: assert property ($rose(state_r.dir[g].sync[1]) |-> $past(sec_rise[g]) && !$past(rst_dir[g]))
            else $error("active rose without secondary edge out of reset");

        primary_toggle_a: assert property (!rst_dir[g] && state_r.dir[g].cnt == div_sel[g] |=> state_r.dir[g].pri != $past(state_r.dir[g].pri))
            else $error("primary clock missed its toggle");

        primary_hold_a: assert property (!rst_dir[g] && state_r.dir[g].cnt != div_sel[g] && !$past(rst_dir[g]) |=> $stable(state_r.dir[g].pri))
            else $error("primary clock toggled early");

        secondary_same_a: assert property (!rst_dir[g] && !ratio_sel[g] && state_r.dir[g].cnt == div_sel[g] |=> state_r.dir[g].sec == state_r.dir[g].pri)
            else $error("secondary clock differs from primary at ratio one");

        secondary_half_a: assert property (!rst_dir[g] && ratio_sel[g] && state_r.dir[g].cnt == div_sel[g] && state_r.dir[g].pri |=> $stable(state_r.dir[g].sec))
            else $error("secondary clock moved on primary fall at ratio two");

        secondary_flip_a: assert property (!rst_dir[g] && ratio_sel[g] && state_r.dir[g].cnt == div_sel[g] && !state_r.dir[g].pri |=> state_r.dir[g].sec != $past(state_r.dir[g].sec))
            else $error("secondary clock missed primary rise at ratio two");
    end

    unmapped_err_a: assert property (apb_req.psel && apb_req.penable && !addr_mapped(apb_req.paddr) |-> pslverr && pready)
        else $error("unmapped access not answered with error");

endmodule

`default_nettype wire

/* File: ucn_user_clock_helper_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ucn_user_clock_helper_test;
    import ucn_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] hr = 2'h3;
    ucn_apb_req_t req = '0;
    logic [31:0] prdata, rd, ctrl;
    logic pready, pslverr, err;
    logic [1:0] src, pri, sec, act, done;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, m, dv[2], rt[2];
    // clock and hang guard
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 50000)
        begin
            miscompares++;
            end_sim();
        end
    end
    ucn_user_clock_helper i_ucn_user_clock_helper (.sys_clk(sys_clk), .rst_n(rst_n),
        .tx_helper_reset(hr[0]), .rx_helper_reset(hr[1]), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_source_clock(src[0]), .tx_primary_user_clock(pri[0]),
        .tx_secondary_user_clock(sec[0]), .tx_active(act[0]),
        .rx_source_clock(src[1]), .rx_primary_user_clock(pri[1]),
        .rx_secondary_user_clock(sec[1]), .rx_active(act[1]));
    // dependent logic takes its active input from the helper
    ucn_seq_model i_ucn_seq_model_tx (.sys_clk(sys_clk), .active(act[0]),
        .helper_reset(hr[0]), .done(done[0]));
    ucn_seq_model i_ucn_seq_model_rx (.sys_clk(sys_clk), .active(act[1]),
        .helper_reset(hr[1]), .done(done[1]));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // ends once pready is seen; the bench timeout catches a hang
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    function automatic logic clk(int d, bit s);
        return s ? sec[d] : pri[d];
    endfunction
    function automatic int exp_per(int d, bit s);
        return 2 * (dv[d] + 1) * ((s && rt[d] != 0) ? 2 : 1);
    endfunction
    // cycles between two rising edges of a user clock
    task automatic per(input int d, input bit s, output int p);
        int k;
        @(negedge sys_clk);
        for (k = 0; k < 99 && clk(d, s) !== 1'b0; k++) @(negedge sys_clk);
        for (k = 0; k < 99 && clk(d, s) !== 1'b1; k++) @(negedge sys_clk);
        @(negedge sys_clk);
        for (p = 1; p < 99 && clk(d, s) !== 1'b0; p++) @(negedge sys_clk);
        for (; p < 99 && clk(d, s) !== 1'b1; p++) @(negedge sys_clk);
    endtask
    task automatic setrst(input int d, input bit v, input bit sw);
        if (sw)
            apb(1'b1, CTRL_OFS, ctrl | (32'(v) << d));
        else
        begin
            @(posedge sys_clk);
            hr[d] <= v;
        end
    endtask
    // main sequence
    initial
    begin
        void'($urandom(26751));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        hr <= 2'h0;
        apb(1'b0, CTRL_OFS, 0);
        chk("ctrl reset", CTRL_RST_VAL, rd);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, STAT_OFS, 0);
        chk("status idle", 32'h3, rd);
        @(negedge sys_clk);
        chk("source clock", {2{sys_clk}}, src);
        apb(1'b1, 12'h008, 32'h1);
        chk("unmapped error", 1, err);
        apb(1'b0, 12'h008, 0);
        chk("unmapped data", 0, rd);
        $display("test basics done");
        for (int it = 0; it < 6; it++)
        begin
            for (int d = 0; d < 2; d++)
            begin
                dv[d] = (it == 0) ? 7 : (it == 1) ? 0 : $urandom_range(7);
                rt[d] = (it == 0) ? 1 : (it == 1) ? 0 : $urandom_range(1);
            end
            ctrl = (rt[1] << 11) | (dv[1] << 8) | (rt[0] << 7) | (dv[0] << 4);
            apb(1'b1, CTRL_OFS, ctrl | 32'hf000_000c);
            apb(1'b0, CTRL_OFS, 0);
            chk("ctrl readback", ctrl, rd);
            repeat (40) @(posedge sys_clk);
            for (int d = 0; d < 2; d++)
            begin
                per(d, 1'b0, n);
                chk("primary period", exp_per(d, 1'b0), n);
                per(d, 1'b1, n);
                chk("secondary period", exp_per(d, 1'b1), n);
                setrst(d, 1'b1, it[0]);
                repeat (2) @(posedge sys_clk);
                @(negedge sys_clk);
                chk("held quiet", 0, {pri[d], sec[d], act[d], done[d]});
                apb(1'b0, STAT_OFS, 0);
                chk("in reset", 1, rd[2 + d]);
                setrst(d, 1'b0, it[0]);
                repeat (2) @(negedge sys_clk);
                chk("active late", 0, act[d]);
                for (m = 0; m < 99 && act[d] !== 1'b1; m++) @(negedge sys_clk);
                chk("active up", 1, act[d]);
                repeat (2) @(negedge sys_clk);
                chk("sequence done", 1, done[d]);
            end
            $display("test %0d done", it);
        end
        end_sim();
    end
endmodule
`default_nettype wire
